// ===== cadc_fifo.sv
/*
 * Small flop-based FIFO between the converter and the frame collector.
 * Assumes a single clock and an active-low asynchronous reset already synchronised.
 */
`default_nettype none

module cadc_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem_r[rd_ptr_r];

   function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   always_comb begin
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = CW'(cnt_r + 1'b1);
      end else if (pop && !push) begin
         cnt_nxt = CW'(cnt_r - 1'b1);
      end
   end

   // Ready is registered so the source sees a clean flop
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= '0;
         in_ready_o <= 1'b1;
      end else begin
         cnt_r <= cnt_nxt;
         in_ready_o <= (cnt_nxt != CW'(DEPTH));
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wrap_inc(wr_ptr_r);
         end
         if (pop) begin
            rd_ptr_r <= wrap_inc(rd_ptr_r);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

endmodule

`default_nettype wire

// ===== cadc_host_model.sv
/*
 * Host model for the current-ADC block: drives the conversion toggle,
 * the shift clock and the upstream chain input, and samples the serial output.
 * Assumes the bench calls its tasks and that the DUT samples on rising clk edges.
 */
`default_nettype none

module cadc_host_model #(
   parameter int QUIET = 50
) (
   input wire logic clk_i,
   input wire logic serial_i,
   output logic conversion_toggle_o,
   output logic shift_clock_o,
   output logic chain_in_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      conversion_toggle_o = 1'b0;
      shift_clock_o = 1'b0;
      chain_in_o = 1'b1;
   end

   // Shift clock stays idle on both sides of every toggle edge
   task automatic flip();
      repeat (QUIET) @(negedge clk_i);
      conversion_toggle_o = ~conversion_toggle_o;
      repeat (QUIET) @(negedge clk_i);
   endtask

   function automatic logic up_bit(input int k);
      return logic'((k % 3) == 1);
   endfunction

   // Bit k is sampled while the clock is low, before its rising edge
   task automatic shift(input int n, output logic [0:1023] bits);
      bits = '0;
      for (int k = 0; k < n; k++) begin
         @(negedge clk_i);
         bits[k] = serial_i;
         shift_clock_o = 1'b1;
         chain_in_o = up_bit(k);
         @(negedge clk_i);
         @(negedge clk_i);
         shift_clock_o = 1'b0;
         @(negedge clk_i);
      end
      // Released chain line must not look like a held bit
      @(negedge clk_i);
      chain_in_o = ~chain_in_o;
   endtask
endmodule

`default_nettype wire

// ===== cadc_pkg.sv
/*
 * Shared constants and types for the current-ADC mode and readout block.
 * Assumes a 100 MHz system clock standing in for the 5 MHz master clock.
 */
`default_nettype none

package cadc_pkg;

   // ---------------------------------------------------------------
   // Clocking
   // ---------------------------------------------------------------
   localparam int SYS_HZ = 100_000_000;
   localparam int MCLK_HZ = 5_000_000;
   localparam int TICK_DIV = SYS_HZ / MCLK_HZ;
   localparam int DIV4_MULT = 4;

   // ---------------------------------------------------------------
   // Internal timing, in microseconds and in master clock periods
   // ---------------------------------------------------------------
   localparam real ADCONV_US = 135.6;
   localparam real ADRST_US = 3.2;
   localparam int ADCONV_TICKS = int'(ADCONV_US * MCLK_HZ / 1.0e6);
   localparam int ADRST_TICKS = int'(ADRST_US * MCLK_HZ / 1.0e6);
   localparam int MRAZ_TICKS = 1552;
   localparam int CMDR_TICKS = 1382;
   localparam int TCNT_W = 12;

   // ---------------------------------------------------------------
   // Data format
   // ---------------------------------------------------------------
   localparam int N_CH = 32;
   localparam int WORD_W = 20;
   localparam int SHORT_W = 16;
   localparam int RAW_W = 22;
   localparam int FIFO_DEPTH = 8;
   localparam logic [19:0] CODE_OFFSET = 20'h01000;
   localparam logic [19:0] CODE_FULL = 20'hfffff;
   localparam logic [19:0] CODE_ZERO = 20'h00000;

   // Integrate/measure states; ST1/ST2/ST7/ST8 are non-continuous
   typedef enum logic [2:0] {ST1, ST2, ST3, ST4, ST5, ST6, ST7, ST8} cadc_state_e;

endpackage

`default_nettype wire

// ===== cadc_top.sv
/*
 * Mode control and serial readout of a 32-channel current-input converter.
 * Assumes host drives conversion_toggle and shift_clock synchronous to clk_sys_i,
 * and the analog side delivers raw signed results over a valid/ready stream.
 */
// Notes on behaviour
// R1: Short integration forces non-continuous mode
// R2: Non-continuous: measure B then A, resume ST6 (code does so from ST5; from ST4 it measures A then B, resumes via ST1-ST3)
// R3: Return to continuous when measure finishes first
// R4: First continuous integration may be short
// R5: Output words are offset binary
// R6: Long select gives 20 bits, else 16
// R7: Zero input codes to offset value
// R8: Saturate high to ones, clip low to zeros
// R9: New data valid when data_ready_n falls
// R10: Shift output on shift clock falling edge
// R11: Host keeps shift clock quiet near toggles
// R12: Chain input follows own words out
// R13: Chain bit captured on shift clock fall
// R14: Frame is 32 words per device
// R15: Host reads after ready, stops before toggle
// R16: Conversion and reset timed from master clock
// R17: Integration may last up to one second
// R18: Ready stays low until shift clock falls
// R19: Divide-by-4 stretches all internal counts
// R20: Integrations alternate between sides A and B
// R21: MSB first, channel zero first
// R22: No stale words; chain feeds shift path
`default_nettype none

module cadc_top #(
   parameter int TICK_DIV = cadc_pkg::TICK_DIV,
   parameter int FIFO_DEPTH = cadc_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic conversion_toggle_i,
   input wire logic shift_clock_i,
   input wire logic chain_in_i,
   input wire logic format_long_i,
   input wire logic clock_divide_by4_i,
   input wire logic raw_valid_i,
   input wire logic signed [cadc_pkg::RAW_W-1:0] raw_value_i,
   output logic raw_ready_o,
   output logic serial_out_o,
   output logic data_ready_n_o,
   output logic inputs_grounded_o,
   output logic continuous_mode_o
);

   localparam int NCH = cadc_pkg::N_CH;
   localparam int WW = cadc_pkg::WORD_W;
   localparam int SW = cadc_pkg::SHORT_W;
   localparam int TOT = NCH * WW;
   localparam int TW = cadc_pkg::TCNT_W;

   // ---------------------------------------------------------------
   // Reset release and master clock tick
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_r;
   logic rst_n;
   logic [15:0] div_cnt_r;
   logic [15:0] div_lim;
   logic tick_r;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // Divide-by-4 slows the tick, so every tick count stretches by four
   assign div_lim = clock_divide_by4_i ? 16'(TICK_DIV * cadc_pkg::DIV4_MULT - 1) // R19
                                       : 16'(TICK_DIV - 1);

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end else begin
         tick_r <= (div_cnt_r >= div_lim);
         div_cnt_r <= (div_cnt_r >= div_lim) ? 16'h0000 : 16'(div_cnt_r + 16'h0001);
      end
   end

   // ---------------------------------------------------------------
   // Integrate/measure state machine
   // ---------------------------------------------------------------
   cadc_pkg::cadc_state_e state_r;
   cadc_pkg::cadc_state_e state_nxt;
   logic init_r;
   logic conversion_toggle_q_r;
   logic conversion_toggle_chg;
   logic mbsy_r;
   logic pend_r;
   logic pend_side_r;
   logic set_pend;
   logic set_pend_side;
   logic start_a;
   logic start_b;

   function automatic logic is_ncont(input cadc_pkg::cadc_state_e s);
      return (s == cadc_pkg::ST1) || (s == cadc_pkg::ST2) ||
             (s == cadc_pkg::ST7) || (s == cadc_pkg::ST8);
   endfunction

   // Progress follows the toggle level, seen here as a change of level
   assign conversion_toggle_chg = init_r && (conversion_toggle_i != conversion_toggle_q_r);

   // No integration timeout: the host may hold a level for up to a second
   always_comb begin // R17
      state_nxt = state_r;
      start_a = 1'b0;
      start_b = 1'b0;
      set_pend = 1'b0;
      set_pend_side = 1'b0;
      if (!init_r) begin
         state_nxt = conversion_toggle_i ? cadc_pkg::ST1 : cadc_pkg::ST8;
      end else if (conversion_toggle_chg) begin
         unique case (state_r)
            cadc_pkg::ST1, cadc_pkg::ST8: state_nxt = state_r;
            cadc_pkg::ST2: state_nxt = cadc_pkg::ST3;
            cadc_pkg::ST3: begin // R4
               state_nxt = cadc_pkg::ST4;
               start_a = 1'b1;
            end
            cadc_pkg::ST4: begin
               if (mbsy_r) begin
                  state_nxt = cadc_pkg::ST1; // R1
                  set_pend = 1'b1;
                  set_pend_side = 1'b1;
               end else begin
                  state_nxt = cadc_pkg::ST5; // R3
                  start_b = 1'b1;
               end
            end
            cadc_pkg::ST5: begin
               if (mbsy_r) begin
                  state_nxt = cadc_pkg::ST8; // R1
                  set_pend = 1'b1;
                  set_pend_side = 1'b0;
               end else begin
                  state_nxt = cadc_pkg::ST4; // R3
                  start_a = 1'b1;
               end
            end
            cadc_pkg::ST6: begin
               state_nxt = cadc_pkg::ST5;
               start_b = 1'b1;
            end
            cadc_pkg::ST7: state_nxt = cadc_pkg::ST6; // R2
         endcase
      end else if (!mbsy_r && !pend_r) begin
         if (state_r == cadc_pkg::ST1) begin
            state_nxt = cadc_pkg::ST2;
         end else if (state_r == cadc_pkg::ST8) begin
            state_nxt = cadc_pkg::ST7; // R2
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= cadc_pkg::ST8;
         init_r <= 1'b0;
         conversion_toggle_q_r <= 1'b0;
         inputs_grounded_o <= 1'b1;
         continuous_mode_o <= 1'b0;
      end else begin
         state_r <= state_nxt;
         init_r <= 1'b1;
         conversion_toggle_q_r <= conversion_toggle_i;
         inputs_grounded_o <= is_ncont(state_nxt); // R2
         continuous_mode_o <= !is_ncont(state_nxt);
      end
   end

   // ---------------------------------------------------------------
   // Measure/reset/auto-zero engine
   // ---------------------------------------------------------------
   logic [TW-1:0] meas_cnt_r;
   logic meas_side_r;
   logic meas_done;
   logic meas_go;
   logic go_side;
   logic [5:0] fill_cnt_r;
   logic published_r;
   logic publish;
   logic [WW-1:0] fill_mem_r [NCH];
   logic fifo_valid;
   logic [WW-1:0] fifo_data;
   logic drain;
   logic [WW-1:0] push_code;

   assign meas_done = mbsy_r && tick_r && (meas_cnt_r == TW'(cadc_pkg::MRAZ_TICKS - 1));
   assign meas_go = start_a || start_b || (meas_done && pend_r);
   assign go_side = start_a ? 1'b0 : (start_b ? 1'b1 : pend_side_r);
   assign drain = mbsy_r && (meas_cnt_r >= TW'(cadc_pkg::ADRST_TICKS)) && // R16
                  (fill_cnt_r != 6'(NCH));
   assign publish = mbsy_r && !published_r && (fill_cnt_r == 6'(NCH)) &&
                    (meas_cnt_r >= TW'(cadc_pkg::CMDR_TICKS));

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         mbsy_r <= 1'b0;
         meas_cnt_r <= '0;
         meas_side_r <= 1'b0;
         pend_r <= 1'b0;
         pend_side_r <= 1'b0;
      end else begin
         if (meas_go) begin
            mbsy_r <= 1'b1;
            meas_cnt_r <= '0;
            meas_side_r <= go_side; // R20
         end else if (meas_done) begin
            mbsy_r <= 1'b0;
         end else if (mbsy_r && tick_r) begin
            meas_cnt_r <= TW'(meas_cnt_r + 1'b1); // R16
         end
         if (set_pend) begin
            pend_r <= 1'b1;
            pend_side_r <= set_pend_side; // R2
         end else if (meas_done) begin
            pend_r <= 1'b0;
         end
      end
   end

   // Frame collection; an unfinished frame is dropped when the next measure cycle starts
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         fill_cnt_r <= 6'h00;
         published_r <= 1'b0;
      end else if (meas_go) begin
         fill_cnt_r <= 6'h00;
         published_r <= 1'b0;
      end else begin
         if (drain && fifo_valid) begin
            fill_cnt_r <= 6'(fill_cnt_r + 1'b1); // R14
         end
         if (publish) begin
            published_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (drain && fifo_valid) begin
         fill_mem_r[fill_cnt_r[4:0]] <= fifo_data;
      end
   end

   // ---------------------------------------------------------------
   // Output coding and buffering
   // ---------------------------------------------------------------
   function automatic logic [WW-1:0] code_of(input logic signed [cadc_pkg::RAW_W-1:0] raw);
      logic signed [cadc_pkg::RAW_W:0] sum;
      sum = raw + $signed({1'b0, cadc_pkg::CODE_OFFSET}); // R7
      if (sum < 0) begin
         return cadc_pkg::CODE_ZERO; // R8
      end else if (sum > $signed({1'b0, cadc_pkg::CODE_FULL})) begin
         return cadc_pkg::CODE_FULL; // R8
      end
      return sum[WW-1:0]; // R5
   endfunction

   assign push_code = code_of(raw_value_i);

   cadc_fifo #(
      .WIDTH(WW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_sys_i),
      .rst_b_i(rst_n),
      .in_valid_i(raw_valid_i),
      .in_data_i(push_code),
      .in_ready_o(raw_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_data),
      .out_ready_i(drain)
   );

   // ---------------------------------------------------------------
   // Serial readout
   // ---------------------------------------------------------------
   logic sclk_q_r;
   logic sclk_fall;
   logic fmt_r;
   logic [TOT-1:0] sr_r;
   logic [TOT-1:0] pack;

   assign sclk_fall = sclk_q_r && !shift_clock_i;

   // Words packed from the top; short words keep their upper 16 bits
   always_comb begin
      pack = '0;
      for (int i = 0; i < NCH; i++) begin
         if (format_long_i) begin
            pack[TOT-1-WW*i -: WW] = fill_mem_r[i]; // R6
         end else begin
            pack[TOT-1-SW*i -: SW] = fill_mem_r[i][WW-1 -: SW]; // R6
         end
      end
   end

   // Chain input enters just below the frame, so upstream words follow ours
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         sr_r <= '0;
         fmt_r <= 1'b1;
         sclk_q_r <= 1'b0;
         data_ready_n_o <= 1'b1;
      end else begin
         sclk_q_r <= shift_clock_i;
         if (publish) begin
            sr_r <= pack; // R21
            fmt_r <= format_long_i;
            data_ready_n_o <= 1'b0; // R9
         end else if (sclk_fall) begin
            sr_r <= {sr_r[TOT-2:0], 1'b0}; // R10
            sr_r[fmt_r ? 0 : TOT - NCH * SW] <= chain_in_i; // R13 R12 R22
            data_ready_n_o <= 1'b1; // R18
         end
      end
   end

   assign serial_out_o = sr_r[TOT-1];

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n);

   logic last_side_r;
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         last_side_r <= 1'b0;
      end else if (!init_r) begin
         // Seeded with the side that the power-up state does not measure first
         last_side_r <= conversion_toggle_i;
      end else if (meas_go) begin
         last_side_r <= go_side;
      end
   end

   a_ncont_entry: assert property ( // R1
      (state_r == cadc_pkg::ST5) && conversion_toggle_chg && mbsy_r |=> state_r == cadc_pkg::ST8 ##1
      inputs_grounded_o)
      else $error("short integration did not enter non-continuous mode");

   a_ncont_resume: assert property ( // R2
      (state_r == cadc_pkg::ST7) && conversion_toggle_chg |=> (state_r == cadc_pkg::ST6) && !mbsy_r)
      else $error("non-continuous mode did not resume at ST6");

   a_cont_return: assert property ( // R3
      (state_r == cadc_pkg::ST4) && conversion_toggle_chg && !mbsy_r |=> (state_r == cadc_pkg::ST5) &&
      mbsy_r && meas_side_r)
      else $error("continuous mode not kept when measure finished");

   a_first_int: assert property ( // R4
      (state_r == cadc_pkg::ST3) |-> !mbsy_r)
      else $error("measure cycle running during ST3");

   a_code_ends: assert property ( // R8
      raw_value_i <= -$signed({1'b0, cadc_pkg::CODE_OFFSET}) |->
      push_code == cadc_pkg::CODE_ZERO)
      else $error("input below the offset not clipped to zero code");

   a_code_top: assert property ( // R8
      raw_value_i >= $signed({1'b0, cadc_pkg::CODE_FULL - cadc_pkg::CODE_OFFSET}) |->
      push_code == cadc_pkg::CODE_FULL)
      else $error("full-scale input not saturated to all ones");

   a_code_zero: assert property ( // R7
      raw_value_i == '0 |-> push_code == cadc_pkg::CODE_OFFSET)
      else $error("zero input did not give offset code");

   a_ready_hold: assert property ( // R18
      !data_ready_n_o && !sclk_fall |=> !data_ready_n_o)
      else $error("data ready released without shift clock fall");

   a_shift_step: assert property ( // R10
      sclk_fall && !publish |=> serial_out_o == $past(sr_r[TOT-2]))
      else $error("serial output did not advance on falling edge");

   a_chain_take: assert property ( // R13
      sclk_fall && !publish && fmt_r |=> sr_r[0] == $past(chain_in_i))
      else $error("chain input not captured on falling edge");

   a_side_alt: assert property ( // R20
      meas_go |-> go_side != last_side_r)
      else $error("measurements did not alternate sides");

   a_meas_len: assert property ( // R16
      meas_go ##1 (mbsy_r && !meas_go) [*8] |-> meas_cnt_r < TW'(cadc_pkg::MRAZ_TICKS))
      else $error("measure counter ran past its cycle length");

endmodule

`default_nettype wire

// ===== current_adc_mode_and_readout_tb.sv
/*
 * Self-checking bench for cadc_top: mode changes, offset coding, word length,
 * daisy-chain pass-through and the FIFO in front of the frame collector.
 * Assumes cadc_pkg and cadc_host_model are compiled first; TICK_DIV is 1.
 */
`default_nettype none

module current_adc_mode_and_readout_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic format_long = 1'b1;
   logic div4 = 1'b0;
   logic raw_valid = 1'b0;
   logic signed [cadc_pkg::RAW_W-1:0] raw_value = '0;
   logic conversion_toggle, sclk, chain, raw_ready, sout, drdy_n, grounded, cont;
   logic [0:1023] bits;
   int failures = 0;
   int samples_checked = 0;

   always #5 clk = ~clk;

   cadc_top #(.TICK_DIV(1), .FIFO_DEPTH(8)) DUT (
      .clk_sys_i(clk), .rst_b_i(rst_b), .conversion_toggle_i(conversion_toggle),
      .shift_clock_i(sclk), .chain_in_i(chain), .format_long_i(format_long),
      .clock_divide_by4_i(div4), .raw_valid_i(raw_valid), .raw_value_i(raw_value),
      .raw_ready_o(raw_ready), .serial_out_o(sout), .data_ready_n_o(drdy_n),
      .inputs_grounded_o(grounded), .continuous_mode_o(cont));

   // Quiet gap is 10 us worth of master ticks at TICK_DIV 1
   cadc_host_model #(.QUIET(50)) HOST (
      .clk_i(clk), .serial_i(sout), .conversion_toggle_o(conversion_toggle),
      .shift_clock_o(sclk), .chain_in_o(chain));

   task automatic results();
      $display("Checked %0d, failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check_val(input string what, input logic [19:0] exp, input logic [19:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_flag(input string what, input logic exp, input logic got);
      check_val(what, {19'h0, exp}, {19'h0, got});
   endtask

   task automatic timeout(input string what);
      failures++;
      $display("BAD %s expected done seen timeout", what);
      results();
   endtask

   function automatic logic signed [21:0] raw_of(input int k);
      case (k)
         0: return 22'h000000;
         1: return 22'h000001;
         2: return 22'h3ff000;
         3: return 22'h3fefff;
         4: return 22'h0fefff;
         5: return 22'h1fffff;
         default: return 22'(k * 32'h123b - 32'h0bb8);
      endcase
   endfunction

   function automatic logic [19:0] exp_code(input logic signed [21:0] r);
      int v;
      v = int'(r) + int'(cadc_pkg::CODE_OFFSET);
      if (v < 0) return cadc_pkg::CODE_ZERO;
      if (v > int'(cadc_pkg::CODE_FULL)) return cadc_pkg::CODE_FULL;
      return v[19:0];
   endfunction

   function automatic logic [19:0] word_at(input int pos, input int w);
      logic [19:0] r;
      r = '0;
      for (int i = 0; i < w; i++) r = {r[18:0], bits[pos + i]};
      return r;
   endfunction

   // Valid is left high between words so it never toggles in one time step
   task automatic send_raw(input logic signed [21:0] v);
      int n;
      n = 0;
      raw_valid = 1'b1;
      raw_value = v;
      while (raw_ready !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 4000) timeout("raw handshake");
      end
      @(negedge clk);
   endtask

   task automatic readout(input logic long_fmt);
      int n;
      int w;
      logic [19:0] e;
      n = 0;
      w = long_fmt ? 20 : 16;
      while (drdy_n !== 1'b0) begin
         @(negedge clk);
         n++;
         if (n > 4000) timeout("data ready");
      end
      repeat (20) @(negedge clk);
      check_flag("data_ready_n held", 1'b0, drdy_n);
      HOST.shift(32 * w + 20, bits);
      check_flag("data_ready_n released", 1'b1, drdy_n);
      for (int c = 0; c < 32; c++) begin
         e = exp_code(raw_of(c));
         check_val("word", long_fmt ? e : {4'h0, e[19:4]}, word_at(c * w, w));
      end
      for (int j = 0; j < 20; j++) begin
         check_flag("chain bit", HOST.up_bit(j), bits[32 * w + j]);
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic scen_long();
      HOST.flip();
      check_flag("continuous after first toggle", 1'b1, cont);
      for (int c = 0; c < 8; c++) send_raw(raw_of(c));
      raw_valid = 1'b0;
      repeat (3) @(negedge clk);
      check_flag("fifo full refuses", 1'b0, raw_ready);
      check_flag("no data before measure", 1'b1, drdy_n);
      HOST.flip();
      for (int c = 8; c < 32; c++) send_raw(raw_of(c));
      raw_valid = 1'b0;
      readout(1'b1);
   endtask

   task automatic scen_short();
      format_long = 1'b0;
      HOST.flip();
      check_flag("continuous kept", 1'b1, cont);
      for (int c = 0; c < 32; c++) send_raw(raw_of(c));
      raw_valid = 1'b0;
      readout(1'b0);
   endtask

   task automatic scen_modes();
      HOST.flip();
      HOST.flip();
      check_flag("short integration grounds", 1'b1, grounded);
      check_flag("continuous dropped", 1'b0, cont);
      repeat (2800) @(negedge clk);
      check_flag("grounded while measuring", 1'b1, grounded);
      repeat (600) @(negedge clk);
      HOST.flip();
      check_flag("integration resumed", 1'b0, grounded);
      HOST.flip();
      check_flag("short first integration", 1'b1, cont);
      repeat (1600) @(negedge clk);
      HOST.flip();
      check_flag("long integration continuous", 1'b1, cont);
      // Side A still measuring: enter through states 1, 2 and 3
      HOST.flip();
      check_flag("busy side A grounds", 1'b1, grounded);
      repeat (3200) @(negedge clk);
      check_flag("side A prepared grounded", 1'b1, grounded);
      HOST.flip();
      check_flag("side A integrating", 1'b1, cont);
      HOST.flip();
      check_flag("short first integration kept", 1'b1, cont);
   endtask

   // A gap long at x1 but short at x4 must force non-continuous mode
   task automatic scen_div4();
      repeat (1600) @(negedge clk);
      div4 = 1'b1;
      HOST.flip();
      repeat (2000) @(negedge clk);
      HOST.flip();
      check_flag("stretched measure still busy", 1'b1, grounded);
   endtask

   initial begin
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      repeat (5) @(negedge clk);
      check_flag("grounded after reset", 1'b1, grounded);
      check_flag("data_ready_n idle", 1'b1, drdy_n);
      scen_long();
      scen_short();
      scen_modes();
      scen_div4();
      results();
   end

   initial begin
      repeat (100000) @(negedge clk);
      timeout("whole run");
   end
endmodule

`default_nettype wire
